//--- adc_ctl_pkg.sv
/*
 Shared constants, register map and types for the converter control block.
 Assumes an APB slave with 8 address bits and 32-bit data.
*/
// Overview of operation
// R1: Left justify puts result bits 9..2 in high byte, bits 1..0 in low 7..6.
// R2: Right justify puts result bits 9..8 in high 1..0, bits 7..0 in low.
// R3: Justify select bit in converter control picks left or right format.
// R4: Eight-bit results always sit in the high byte; low byte reads zero.
// R5: In ten-bit mode the six unused result bits read zero.
// R6: Both result bytes are read-only; writes leave them unchanged.
// R7: Pin enable register holds one bit per pin; one means converter use.
// R8: Writing pin enables aborts any conversion and starts none.
// R9: A disabled selected pin converts the low reference, giving zeroes.
// R10: Writing status control starts a conversion, aborting any running one.
// R11: Writing converter control aborts any conversion and starts none.
// R12: Mode control starts sampling; sampling end starts SAR; SAR reports done.
// R13: Reference channels skip sampling; the SAR takes the reference directly.
// R14: SAR output moves into a result register read from the bus side.
// R15: Sampling and SAR conversion never run together.
// R16: The sampler gates off its clocks whenever it is not sampling.
// R17: The sample window lasts exactly 14 conversion clock cycles.
// R18: Done flag sets at each completion and clears on result byte reads.
// R19: Writing status control clears the done flag.
// R20: Continuous bit repeats conversions; otherwise one per status write.
// R21: Channel codes 0..7 pick pins, 1E high ref, 1F and 08..1D low ref.
// R22: An abort leaves the result register unchanged, and the done flag too unless it is a status write.
package adc_ctl_pkg;
    localparam logic [7:0] CONV_CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_CTRL_OFS = 8'h04;
    localparam logic [7:0] RES_HIGH_OFS  = 8'h08;
    localparam logic [7:0] RES_LOW_OFS   = 8'h0C;
    localparam logic [7:0] PIN_EN_OFS    = 8'h10;
    localparam int         DONE_BIT      = 7;
    localparam int         IRQ_EN_BIT    = 6;
    localparam int         CONT_BIT      = 5;
    localparam int         JUSTIFY_BIT   = 5;
    localparam int         RES10_BIT     = 4;
    localparam logic [5:0] CONV_CTRL_RST = 6'h00;
    localparam logic [6:0] STAT_CTRL_RST = 7'h00;
    localparam logic [7:0] PIN_EN_RST    = 8'h00;
    localparam logic [3:0] SAMPLE_LAST   = 4'hD;
    localparam logic [6:0] TICK_BASE     = 7'h04;
    localparam logic [4:0] CH_HIGH_REF   = 5'h1E;
    localparam logic [3:0] MSB_IDX       = 4'h9;
    localparam logic [3:0] STOP8_IDX     = 4'h2;
    localparam logic [9:0] MSB_TRIAL     = 10'h200;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_t;

    typedef struct packed {
        logic       justify;
        logic       res10;
        logic [3:0] prs;
    } conv_ctrl_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } result_bytes_t;

    function automatic result_bytes_t format_result(
        input logic [9:0] r,
        input logic       res10,
        input logic       justify
    );
        result_bytes_t b;
        b = '0;
        if (!res10) begin
            b.high = r[7:0]; // R4
        end else if (justify) begin
            b.high = {6'h00, r[9:8]}; // R2 R5
            b.low  = r[7:0]; // R2
        end else begin
            b.high = r[9:2]; // R1
            b.low  = {r[1:0], 6'h00}; // R1 R5
        end
        return b;
    endfunction
endpackage

//--- adc_ctl.sv
/*
 Control logic of a ten-bit successive approximation converter: APB
 registers, result formatting, sample and SAR sequencing.
 Assumes an external comparator (asynchronous, high when the input is above
 the trial code) and an external sampler whose clocks follow sh_clk_en_q.
*/
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module adc_ctl (
    // Clock, reset and freeze.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog side.
    input  wire logic        comp_in,
    output logic             sh_clk_en_q,
    output logic             sar_active_q,
    output logic [2:0]       pin_sel_q,
    output logic             ref_high_q,
    output logic             ref_low_q,
    output logic [7:0]       pin_en_out_q,
    output logic [9:0]       trial_code_q
);
    import adc_ctl_pkg::*;

    conv_state_t   state_q;
    conv_state_t   state_d;
    conv_ctrl_t    ctrl_q;
    result_bytes_t rb;
    logic [6:0]    stat_q;
    logic [7:0]    pin_en_q;
    logic          done_flag_q;
    logic [9:0]    result_q;
    logic          res10_q;
    logic [3:0]    cnt_q;
    logic [3:0]    bit_q;
    logic [5:0]    div_q;
    logic [5:0]    reload;
    logic          comp_meta_q;
    logic          comp_s_q;
    logic [31:0]   rdata_d;
    logic          hit_ctrl;
    logic          hit_stat;
    logic          hit_rh;
    logic          hit_rl;
    logic          hit_pe;
    logic          mapped;
    logic          acc;
    logic          wr;
    logic          wr_ctrl;
    logic          wr_stat;
    logic          wr_pe;
    logic          rd_res;
    logic          abort;
    logic          tick;
    logic          done;
    logic          last;
    logic [3:0]    stop;
    logic [9:0]    mask;
    logic [9:0]    final_code;
    logic [4:0]    sch;
    logic          s_ref;
    logic          s_high;

    // Comparator synchroniser.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_meta_q <= 1'b0;
            comp_s_q    <= 1'b0;
        end else if (ce) begin
            comp_meta_q <= comp_in;
            comp_s_q    <= comp_meta_q;
        end
    end

    // Address decode and bus strobes.
    assign hit_ctrl = (paddr == CONV_CTRL_OFS);
    assign hit_stat = (paddr == STAT_CTRL_OFS);
    assign hit_rh   = (paddr == RES_HIGH_OFS);
    assign hit_rl   = (paddr == RES_LOW_OFS);
    assign hit_pe   = (paddr == PIN_EN_OFS);
    assign mapped   = hit_ctrl | hit_stat | hit_rh | hit_rl | hit_pe;
    assign acc      = ce & psel & penable & pready;
    assign wr       = acc & pwrite & mapped;
    assign wr_ctrl  = wr & hit_ctrl;
    assign wr_stat  = wr & hit_stat;
    assign wr_pe    = wr & hit_pe;
    assign rd_res   = acc & ~pwrite & (hit_rh | hit_rl);
    assign abort    = wr_ctrl | wr_stat | wr_pe; // R8 R10 R11

    // Result bytes as the bus sees them.
    assign rb = format_result(res10_q ? result_q : {2'b00, result_q[9:2]},
                              res10_q, ctrl_q.justify); // R3 R14

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata_d[5:0] = ctrl_q;
        end else if (hit_stat) begin
            rdata_d[7:0] = {done_flag_q, stat_q};
        end else if (hit_rh) begin
            rdata_d[7:0] = rb.high;
        end else if (hit_rl) begin
            rdata_d[7:0] = rb.low;
        end else if (hit_pe) begin
            rdata_d[7:0] = pin_en_q;
        end
    end

    // Zero-wait APB answer, prepared in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (psel && !penable) begin
                prdata <= rdata_d;
            end
        end
    end

    // Software registers; result bytes take no write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= CONV_CTRL_RST;
            stat_q   <= STAT_CTRL_RST;
            pin_en_q <= PIN_EN_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata[5:0];
            end
            if (wr_stat) begin
                stat_q <= pwdata[6:0];
            end
            if (wr_pe) begin
                pin_en_q <= pwdata[7:0]; // R7
            end
        end
    end

    // Done flag: completion wins over a clearing read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag_q <= 1'b0;
        end else if (done) begin
            done_flag_q <= 1'b1; // R18
        end else if (wr_stat || rd_res) begin
            done_flag_q <= 1'b0; // R18 R19
        end
    end

    // Conversion clock divider.
    assign reload = 6'((({3'b000, ctrl_q.prs} + 7'h01) * TICK_BASE) - 7'h01);
    assign tick   = ce & (state_q != ST_IDLE) & (div_q == 6'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 6'h00;
        end else if (ce) begin
            if (abort || state_q == ST_IDLE || div_q == 6'h00) begin
                div_q <= reload;
            end else begin
                div_q <= div_q - 6'h01;
            end
        end
    end

    // Channel decode for the conversion about to start.
    assign sch    = wr_stat ? pwdata[4:0] : stat_q[4:0];
    assign s_high = (sch == CH_HIGH_REF); // R21
    assign s_ref  = (sch[4:3] != 2'b00) | ~pin_en_q[sch[2:0]]; // R9 R21

    // SAR step.
    assign stop       = res10_q ? 4'h0 : STOP8_IDX;
    assign mask       = 10'h001 << bit_q;
    assign final_code = (trial_code_q & ~mask) | (comp_s_q ? mask : 10'h000);
    assign last       = (bit_q == stop);
    assign done       = tick & (state_q == ST_CONVERT) & last & ~abort;

    // Mode control sequencing.
    always_comb begin
        state_d = state_q;
        if (abort) begin
            state_d = !wr_stat ? ST_IDLE : (s_ref ? ST_CONVERT : ST_SAMPLE); // R10 R13
        end else if (tick) begin
            case (state_q)
                ST_SAMPLE: begin
                    if (cnt_q == SAMPLE_LAST) begin
                        state_d = ST_CONVERT; // R12 R17
                    end
                end
                ST_CONVERT: begin
                    if (last) begin
                        state_d = !stat_q[CONT_BIT] ? ST_IDLE :
                                  (s_ref ? ST_CONVERT : ST_SAMPLE); // R20
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q      <= ST_IDLE;
            sh_clk_en_q  <= 1'b0;
            sar_active_q <= 1'b0;
        end else if (ce) begin
            state_q      <= state_d;
            sh_clk_en_q  <= (state_d == ST_SAMPLE); // R16
            sar_active_q <= (state_d == ST_CONVERT); // R15
        end
    end

    // Sample window count, bit index and trial code.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q        <= 4'h0;
            bit_q        <= MSB_IDX;
            trial_code_q <= 10'h000;
            res10_q      <= 1'b0;
        end else if (ce) begin
            if (abort || (tick && state_q == ST_CONVERT && last)) begin
                cnt_q        <= 4'h0;
                bit_q        <= MSB_IDX;
                trial_code_q <= (state_d == ST_CONVERT) ? MSB_TRIAL : 10'h000;
                res10_q      <= wr_ctrl ? pwdata[RES10_BIT] : ctrl_q.res10;
            end else if (tick && state_q == ST_SAMPLE) begin
                cnt_q <= cnt_q + 4'h1; // R17
                if (cnt_q == SAMPLE_LAST) begin
                    trial_code_q <= MSB_TRIAL; // R12
                end
            end else if (tick && state_q == ST_CONVERT) begin
                bit_q        <= bit_q - 4'h1;
                trial_code_q <= final_code | (mask >> 1);
            end
        end
    end

    // Result capture and analog selects.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q     <= 10'h000;
            pin_sel_q    <= 3'h0;
            ref_high_q   <= 1'b0;
            ref_low_q    <= 1'b0;
            pin_en_out_q <= PIN_EN_RST;
        end else if (ce) begin
            pin_en_out_q <= pin_en_q; // R7
            if (done) begin
                result_q <= final_code; // R14 R22
            end
            if (wr_stat) begin
                pin_sel_q  <= sch[2:0];
                ref_high_q <= s_high; // R13
                ref_low_q  <= s_ref & ~s_high; // R9
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_sample_end;
        state_q == ST_SAMPLE && tick && cnt_q == SAMPLE_LAST && !abort;
    endsequence
    sequence s_sar_runs;
        sar_active_q && !sh_clk_en_q;
    endsequence

    property p_excl;
        !(sh_clk_en_q && sar_active_q);
    endproperty
    a_excl: assert property (p_excl) else $error("sampler and SAR overlap"); // R15

    property p_window;
        s_sample_end |=> s_sar_runs;
    endproperty
    a_window: assert property (p_window) else $error("sample end did not start SAR"); // R17

    property p_cnt;
        state_q == ST_SAMPLE |-> cnt_q <= SAMPLE_LAST && sh_clk_en_q;
    endproperty
    a_cnt: assert property (p_cnt) else $error("sample count overrun"); // R17

    property p_pe_abort;
        wr_pe |=> state_q == ST_IDLE && !sar_active_q && !sh_clk_en_q;
    endproperty
    a_pe_abort: assert property (p_pe_abort) else $error("pin write left converter busy"); // R8

    property p_ctrl_abort;
        wr_ctrl |=> state_q == ST_IDLE && $stable(result_q) && $stable(done_flag_q);
    endproperty
    a_ctrl_abort: assert property (p_ctrl_abort) else $error("control write misbehaved"); // R11

    property p_start;
        wr_stat |=> state_q != ST_IDLE && !done_flag_q;
    endproperty
    a_start: assert property (p_start) else $error("status write did not start"); // R10

    property p_ref;
        wr_stat && s_ref |=> s_sar_runs;
    endproperty
    a_ref: assert property (p_ref) else $error("reference channel sampled"); // R13

    property p_done;
        done |=> done_flag_q && result_q == $past(final_code);
    endproperty
    a_done: assert property (p_done) else $error("completion not recorded"); // R18

    property p_ro;
        wr && (hit_rh || hit_rl) && !done |=> $stable(result_q);
    endproperty
    a_ro: assert property (p_ro) else $error("result byte changed by write"); // R6

    property p_rdclr;
        rd_res && !done |=> !done_flag_q;
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("result read kept flag"); // R18

    property p_single;
        done && !stat_q[CONT_BIT] |=> state_q == ST_IDLE;
    endproperty
    a_single: assert property (p_single) else $error("single mode continued"); // R20
endmodule

//--- adc_far_side.sv
/*
 Behavioural comparator and analog pins facing the converter control block.
 Assumes pin levels are given as codes lying half a step above the code.
*/
`timescale 1ns/1ps
module adc_far_side (
    // Clock.
    input  wire logic            pclk,
    // Converter side.
    input  wire logic [2:0]      pin_sel_q,
    input  wire logic            ref_high_q,
    input  wire logic            ref_low_q,
    input  wire logic            sar_active_q,
    input  wire logic [9:0]      trial_code_q,
    // Pin levels.
    input  wire logic [7:0][9:0] level,
    // Comparator.
    output logic                 comp_in
);
    logic       flip_q = 1'b0;
    logic [9:0] vin;

    // Outside a conversion the output wanders, so stale values are never trusted.
    always_ff @(posedge pclk) begin
        flip_q <= ~flip_q;
    end

    always_comb begin
        vin = ref_high_q ? 10'h3FF : level[pin_sel_q];
        if (!sar_active_q) begin
            comp_in = flip_q;
        end else if (ref_low_q) begin
            comp_in = 1'b0;
        end else begin
            comp_in = (trial_code_q <= vin);
        end
    end
endmodule

//--- sar_adc_result_and_sequencer_test.sv
/*
 Self-checking bench for the converter control block over APB.
 Assumes the comparator model in adc_far_side and zero wait APB answers.
*/
`timescale 1ns/1ps
module sar_adc_result_and_sequencer_test;
    import adc_ctl_pkg::*;
    logic            pclk = 1'b0;
    logic            presetn = 1'b0;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic [7:0]      paddr = 8'h00;
    logic [31:0]     pwdata = 32'h0;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            comp_in;
    logic            sh_clk_en_q;
    logic            sar_active_q;
    logic [2:0]      pin_sel_q;
    logic            ref_high_q;
    logic            ref_low_q;
    logic [7:0]      pin_en_out_q;
    logic [9:0]      trial_code_q;
    logic [7:0][9:0] lev;
    int              err_count = 0;
    int              compares = 0;
    int              cyc = 0;
    int              sh_cnt = 0;
    logic [31:0]     q;
    logic            e;

    adc_ctl uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comp_in(comp_in), .sh_clk_en_q(sh_clk_en_q),
        .sar_active_q(sar_active_q), .pin_sel_q(pin_sel_q), .ref_high_q(ref_high_q),
        .ref_low_q(ref_low_q), .pin_en_out_q(pin_en_out_q), .trial_code_q(trial_code_q));
    adc_far_side far (.pclk(pclk), .pin_sel_q(pin_sel_q), .ref_high_q(ref_high_q),
        .ref_low_q(ref_low_q), .sar_active_q(sar_active_q), .trial_code_q(trial_code_q),
        .level(lev), .comp_in(comp_in));

    always #10 pclk = ~pclk;

    task automatic wrap_up;
        if (err_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] x, input logic [31:0] s);
        compares++;
        if (s !== x) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask

    // Sampling time is counted here; overlap with the SAR is never allowed.
    always @(posedge pclk) begin
        cyc++;
        if (sh_clk_en_q === 1'b1) sh_cnt++;
        if (sh_clk_en_q === 1'b1 && sar_active_q === 1'b1) check("overlap", 0, 1);
        if (cyc == 40000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [15:0] fmt(input logic [9:0] r, input logic t, input logic j);
        if (!t) return {r[9:2], 8'h00};
        if (j) return {6'h00, r[9:8], r[7:0]};
        return {r[9:2], r[1:0], 6'h00};
    endfunction

    task automatic wait_done;
        int n;
        n = 0;
        q = 32'h0;
        while (q[DONE_BIT] !== 1'b1 && n < 400) begin
            apb(1'b0, STAT_CTRL_OFS, 32'h0);
            n++;
        end
    endtask

    task automatic check_res(input logic [15:0] x);
        apb(1'b0, RES_HIGH_OFS, 32'h0);
        check("result_high_byte", {24'h0, x[15:8]}, q);
        apb(1'b0, RES_LOW_OFS, 32'h0);
        check("result_low_byte", {24'h0, x[7:0]}, q);
    endtask

    task automatic conv(input logic [7:0] c, input logic [7:0] ch, output int d);
        int s0;
        apb(1'b1, CONV_CTRL_OFS, {24'h0, c});
        s0 = sh_cnt;
        apb(1'b1, STAT_CTRL_OFS, {24'h0, ch});
        wait_done();
        check("conversion_done_flag", 1, q[DONE_BIT]);
        d = sh_cnt - s0;
    endtask

    task automatic t_regs;
        logic [7:0] a [5] = '{CONV_CTRL_OFS, STAT_CTRL_OFS, RES_HIGH_OFS, RES_LOW_OFS, PIN_EN_OFS};
        foreach (a[i]) begin
            apb(1'b0, a[i], 32'h0);
            check("reset_value", 0, q);
        end
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped_err", 1, e);
        apb(1'b1, PIN_EN_OFS, 32'hA5);
        apb(1'b0, PIN_EN_OFS, 32'h0);
        check("analog_pin_enables", 32'hA5, q);
        check("pin_en_out", 8'hA5, pin_en_out_q);
        apb(1'b1, RES_HIGH_OFS, 32'hFF);
        apb(1'b1, RES_LOW_OFS, 32'hFF);
        check_res(16'h0000);
    endtask

    task automatic t_formats;
        int d;
        logic [7:0] c;
        apb(1'b1, PIN_EN_OFS, 32'hFF);
        for (int f = 0; f < 3; f++) begin
            c = 8'h01;
            c[RES10_BIT] = (f != 0);
            c[JUSTIFY_BIT] = (f == 2);
            conv(c, 8'h03, d);
            check("pin_sel", 3, pin_sel_q);
            check("sample_len", 1, d > 8 * 13 && d <= 8 * 14);
            check_res(fmt(lev[3], f != 0, f == 2));
            apb(1'b0, STAT_CTRL_OFS, 32'h0);
            check("flag_after_read", 0, q[DONE_BIT]);
        end
    endtask

    task automatic t_channels;
        int d;
        logic [4:0] cs [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 5'h08, 5'h1D, 5'h1E, 5'h1F};
        logic [9:0] x;
        foreach (cs[i]) begin
            conv(8'h30, {3'h0, cs[i]}, d);
            x = cs[i] < 8 ? lev[cs[i][2:0]] : (cs[i] == 5'h1E ? 10'h3FF : 10'h000);
            check_res(fmt(x, 1'b1, 1'b1));
            check("sampled", cs[i] < 8, d > 0);
            check("ref_high", cs[i] == 5'h1E, ref_high_q);
            check("ref_low", cs[i] > 5'h07 && cs[i] != 5'h1E, ref_low_q);
        end
        apb(1'b1, PIN_EN_OFS, 32'hF7);
        conv(8'h30, 8'h03, d);
        check_res(16'h0000);
        check("ref_low_disabled", 1, ref_low_q);
        check("sampled_disabled", 0, d);
        check("pin_en_out", 8'hF7, pin_en_out_q);
    endtask

    task automatic t_restart;
        apb(1'b1, PIN_EN_OFS, 32'hFF);
        apb(1'b1, STAT_CTRL_OFS, 32'h21);
        wait_done();
        repeat (20) @(posedge pclk);
        apb(1'b1, STAT_CTRL_OFS, 32'h42);
        apb(1'b0, STAT_CTRL_OFS, 32'h0);
        check("status_readback", 32'h42, q);
        wait_done();
        check_res(fmt(lev[2], 1'b1, 1'b1));
        repeat (300) @(posedge pclk);
        apb(1'b0, STAT_CTRL_OFS, 32'h0);
        check("single_no_repeat", 32'h42, q);
    endtask

    task automatic t_abort;
        apb(1'b1, STAT_CTRL_OFS, 32'h24);
        wait_done();
        check_res(fmt(lev[4], 1'b1, 1'b1));
        lev[4] <= 10'h1C3;
        wait_done();
        apb(1'b0, RES_LOW_OFS, 32'h0);
        wait_done();
        check_res(fmt(10'h1C3, 1'b1, 1'b1));
        for (int k = 0; k < 2; k++) begin
            lev[4] <= 10'h1C3;
            apb(1'b1, STAT_CTRL_OFS, 32'h24);
            wait_done();
            lev[4] <= 10'h0E5;
            repeat (66) @(posedge pclk);
            if (k == 0) apb(1'b1, CONV_CTRL_OFS, 32'h30);
            else apb(1'b1, PIN_EN_OFS, 32'hFF);
            repeat (200) @(posedge pclk);
            apb(1'b0, STAT_CTRL_OFS, 32'h0);
            check("flag_kept", 1, q[DONE_BIT]);
            check_res(fmt(10'h1C3, 1'b1, 1'b1));
            repeat (200) @(posedge pclk);
            apb(1'b0, STAT_CTRL_OFS, 32'h0);
            check("no_restart", 0, q[DONE_BIT]);
            check("sar_idle", 0, sar_active_q);
            check("sampler_idle", 0, sh_clk_en_q);
        end
    endtask

    initial begin
        for (int i = 0; i < 8; i++) lev[i] = 10'h2D6 ^ (10'h05B * i);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_formats();
        t_channels();
        t_restart();
        t_abort();
        wrap_up();
    end
endmodule
